// *** include/icache_pkg.sv ***
package icache_pkg;
   // Data path and line geometry
   localparam int DATA_W = 64;
   localparam int TAG_W = 20;
   localparam int WAYS = 4;
   localparam int SETS = 128;
   localparam int LINES = 512;
   localparam int WORDS = 2048;
   localparam int LINE_WORDS = 4;
   localparam int FIFO_DEPTH = 16;
   // Fetch address field positions
   localparam int BYTE_LO = 0;
   localparam int WORD_LO = 3;
   localparam int SET_LO = 5;
   localparam int WAY_LO = 10;
   localparam int SUB_LO = 12;
   localparam int TAG_LO = 14;
   // Fixed base of the switchable 16 KB region
   localparam logic [31:0] REGION_BASE = 32'hFFA1_0000;
   localparam logic [1:0] LAST_WORD = 2'h3;
   typedef enum logic [1:0] {S_IDLE, S_REQ, S_FILL} fill_state_t;
endpackage

// *** rtl/icache_ctrl.sv ***
// Summary of operation
// - In cache mode a missing line may go into any of four ways.
// - Subbank chosen by fetch address bits 13 to 12.
// - Set within a subbank chosen by fetch address bits 9 to 5.
// - Way number sits at storage address bits 11 to 10.
// - Each way has its own lock input, any mix allowed.
// - An input selects plain or priority-modified least recently used.
// - A miss with a victim way available fetches a whole 32-byte line into it; with no victim it fetches one word.
// - Fill is four 64-bit transfers, target word first, then wrapping.
// - Each line keeps a 20-bit tag compared with the fetch address.
// - Each line also keeps priority, age and valid flag.
// - Byte bits of the fetch address pick one byte in the fetched 64-bit word.
// - Direct reads and writes are refused while the region is cache.
// - A started fill always runs to its end, never aborted.
// - Only the 16 KB region switches; fixed SRAM lies outside this block.
// - The region base address is one fixed constant.
// - Address splits into offset, set index and tag fields.
// - Hit only on a tag match with the valid flag set.
// - Locked ways are never chosen as victims.
// - Low priority lines replace only low; high prefers low first.
// - Invalid ways fill in order 0,1,2,3 before age is used.

// ****************************************
// Fill buffer
// ****************************************
module sync_fifo #(
   parameter int WIDTH = 64,
   parameter int DEPTH = 16
) (
   input wire logic clock,
   input wire logic arst_n,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW:0] wp_r, rp_r, wp_nxt, rp_nxt;
   logic push, pop, room_r, room_nxt;

   // Registered so the bus sees ready straight from a flop
   assign in_ready = room_r;
   assign out_valid = wp_r != rp_r;
   assign out_data = mem_r[rp_r[AW-1:0]];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   always_comb begin
      wp_nxt = push ? wp_r + 1'b1 : wp_r;
      rp_nxt = pop ? rp_r + 1'b1 : rp_r;
      room_nxt = (wp_nxt - rp_nxt) != (AW+1)'(DEPTH);
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         wp_r <= '0;
         rp_r <= '0;
         room_r <= 1'b1;
      end else begin
         wp_r <= wp_nxt;
         rp_r <= rp_nxt;
         room_r <= room_nxt;
      end
   end

   always_ff @(posedge clock) begin
      if (push) begin
         mem_r[wp_r[AW-1:0]] <= in_data;
      end
   end
endmodule

// ****************************************
// Instruction cache controller
// ****************************************
module icache_ctrl (
   input wire logic clock,
   input wire logic arst_n,
   input wire logic cache_enable,
   input wire logic modified_lru,
   input wire logic [3:0] way_lock,
   input wire logic line_prio,
   input wire logic fetch_req,
   input wire logic [31:0] fetch_addr,
   output logic fetch_ready,
   output logic fetch_valid,
   output logic [63:0] fetch_data,
   output logic [7:0] fetch_byte,
   input wire logic mem_req,
   input wire logic mem_we,
   input wire logic [31:0] mem_addr,
   input wire logic [63:0] mem_wdata,
   output logic mem_valid,
   output logic [63:0] mem_rdata,
   output logic mem_blocked,
   output logic ext_req,
   output logic [31:0] ext_addr,
   output logic ext_burst,
   input wire logic ext_gnt,
   input wire logic ext_rvalid,
   output logic ext_rready,
   input wire logic [63:0] ext_rdata
);
   // ****************************************
   // Helpers
   // ****************************************
   function automatic logic [6:0] set_of(input logic [31:0] a);
      return {a[icache_pkg::SUB_LO+:2], a[icache_pkg::SET_LO+:5]};
   endfunction

   function automatic logic [19:0] tag_of(input logic [31:0] a);
      return {a[31:icache_pkg::TAG_LO], a[icache_pkg::WAY_LO+:2]};
   endfunction

   function automatic logic [10:0] dix(input logic [6:0] s,
         input logic [1:0] w, input logic [1:0] wd);
      return {s[6:5], w, s[4:0], wd};
   endfunction

   function automatic logic [7:0] byte_sel(input logic [63:0] d,
         input logic [2:0] b);
      return d[{b, 3'h0}+:8];
   endfunction

   // ****************************************
   // Storage
   // ****************************************
   logic [19:0] tag_r [icache_pkg::LINES];
   logic [icache_pkg::LINES-1:0] valid_r;
   logic [icache_pkg::LINES-1:0] prio_r;
   logic [1:0] age_r [icache_pkg::LINES];
   logic [63:0] data_r [icache_pkg::WORDS];

   icache_pkg::fill_state_t state_r, state_nxt;
   logic [31:0] addr_r, addr_nxt;
   logic [1:0] way_r, way_nxt, cnt_r, cnt_nxt;
   logic alloc_r, alloc_nxt, inprio_r, inprio_nxt;
   logic ext_req_r, ereq_nxt, ready_r, ready_nxt;
   logic fv_r, fv_nxt, mv_r, mv_nxt, mb_r, mb_nxt;
   logic [63:0] fd_r, fd_nxt, md_r, md_nxt;
   logic [7:0] fb_r, fb_nxt;

   logic [6:0] fset, lru_set;
   logic [19:0] ftag;
   logic [3:0] hit_vec, vld4, pri4;
   logic [7:0] age8;
   logic hit_any, lru_en, fill_done, take, last, mem_act, dwe;
   logic [1:0] hit_way, lru_way, wd;
   logic [2:0] vic;
   logic [1:0] age4_nxt [icache_pkg::WAYS];
   logic [10:0] dwi;
   logic [63:0] dwd, q_data;
   logic q_valid, q_ready, in_region;

   // ****************************************
   // Lookup and victim choice
   // ****************************************
   function automatic logic [2:0] pick_victim(input logic [3:0] vld,
         input logic [3:0] pri, input logic [7:0] age,
         input logic [3:0] lock, input logic md, input logic inp);
      logic [3:0] part;
      logic [1:0] best, bage;
      logic found;
      part = ~lock;
      best = '0;
      bage = '0;
      found = 1'b0;
      for (int i = 0; i < icache_pkg::WAYS; i++) begin
         if (part[i] && !vld[i] && !found) begin
            best = 2'(i);
            found = 1'b1;
         end
      end
      if (!found) begin
         if (md) begin
            if (|(part & ~pri)) begin
               part = part & ~pri;
            end else if (!inp) begin
               part = '0;
            end
         end
         for (int i = 0; i < icache_pkg::WAYS; i++) begin
            if (part[i] && (!found || age[2*i+:2] >= bage)) begin
               best = 2'(i);
               bage = age[2*i+:2];
               found = 1'b1;
            end
         end
      end
      return {found, best};
   endfunction

   always_comb begin
      fset = set_of(fetch_addr);
      ftag = tag_of(fetch_addr);
      hit_way = '0;
      for (int i = 0; i < icache_pkg::WAYS; i++) begin
         vld4[i] = valid_r[{fset, 2'(i)}];
         pri4[i] = prio_r[{fset, 2'(i)}];
         age8[2*i+:2] = age_r[{fset, 2'(i)}];
         hit_vec[i] = vld4[i] && tag_r[{fset, 2'(i)}] == ftag;
         if (hit_vec[i]) begin
            hit_way = 2'(i);
         end
      end
      hit_any = |hit_vec;
      vic = pick_victim(vld4, pri4, age8, way_lock, modified_lru,
            line_prio);
   end

   // ****************************************
   // Fetch and fill sequencing
   // ****************************************
   // Direct access stalls the fill drain; the buffer absorbs the burst
   assign in_region = mem_addr[31:icache_pkg::TAG_LO] ==
         icache_pkg::REGION_BASE[31:icache_pkg::TAG_LO];
   assign mem_act = mem_req && in_region && !cache_enable;
   assign q_ready = state_r == icache_pkg::S_FILL && !mem_act;
   assign take = q_valid && q_ready;
   assign last = cnt_r == (alloc_r ? icache_pkg::LAST_WORD : 2'h0);
   assign wd = addr_r[icache_pkg::WORD_LO+:2] + cnt_r;

   always_comb begin
      state_nxt = state_r;
      addr_nxt = addr_r;
      way_nxt = way_r;
      alloc_nxt = alloc_r;
      inprio_nxt = inprio_r;
      cnt_nxt = cnt_r;
      ereq_nxt = ext_req_r;
      fv_nxt = 1'b0;
      fd_nxt = fd_r;
      fb_nxt = fb_r;
      lru_en = 1'b0;
      lru_set = fset;
      lru_way = hit_way;
      fill_done = 1'b0;
      dwe = 1'b0;
      dwi = dix(set_of(addr_r), way_r, wd);
      dwd = q_data;
      unique case (state_r)
         icache_pkg::S_IDLE: begin
            if (fetch_req && ready_r) begin
               if (cache_enable && hit_any) begin
                  fv_nxt = 1'b1;
                  fd_nxt = data_r[dix(fset, hit_way,
                        fetch_addr[icache_pkg::WORD_LO+:2])];
                  fb_nxt = byte_sel(fd_nxt, fetch_addr[2:0]);
                  lru_en = 1'b1;
               end else begin
                  addr_nxt = fetch_addr;
                  alloc_nxt = cache_enable && vic[2];
                  way_nxt = vic[1:0];
                  inprio_nxt = line_prio;
                  cnt_nxt = '0;
                  ereq_nxt = 1'b1;
                  state_nxt = icache_pkg::S_REQ;
               end
            end
         end
         icache_pkg::S_REQ: begin
            if (ext_gnt) begin
               ereq_nxt = 1'b0;
               state_nxt = icache_pkg::S_FILL;
            end
         end
         icache_pkg::S_FILL: begin
            if (take) begin
               dwe = alloc_r;
               if (cnt_r == 2'h0) begin
                  fv_nxt = 1'b1;
                  fd_nxt = q_data;
                  fb_nxt = byte_sel(q_data, addr_r[2:0]);
               end
               cnt_nxt = cnt_r + 2'h1;
               if (last) begin
                  state_nxt = icache_pkg::S_IDLE;
                  fill_done = alloc_r;
                  lru_en = alloc_r;
                  lru_set = set_of(addr_r);
                  lru_way = way_r;
               end
            end
         end
      endcase
      ready_nxt = state_nxt == icache_pkg::S_IDLE;
      mv_nxt = 1'b0;
      md_nxt = md_r;
      if (mem_act) begin
         if (mem_we) begin
            dwe = 1'b1;
            dwi = mem_addr[13:3];
            dwd = mem_wdata;
         end else begin
            mv_nxt = 1'b1;
            md_nxt = data_r[mem_addr[13:3]];
         end
      end
      mb_nxt = mem_req && in_region && cache_enable;
      for (int i = 0; i < icache_pkg::WAYS; i++) begin
         if (2'(i) == lru_way) begin
            age4_nxt[i] = 2'h0;
         end else if (age_r[{lru_set, 2'(i)}] <
               age_r[{lru_set, lru_way}]) begin
            age4_nxt[i] = age_r[{lru_set, 2'(i)}] + 2'h1;
         end else begin
            age4_nxt[i] = age_r[{lru_set, 2'(i)}];
         end
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         state_r <= icache_pkg::S_IDLE;
         addr_r <= '0;
         way_r <= '0;
         alloc_r <= 1'b0;
         inprio_r <= 1'b0;
         cnt_r <= '0;
         ext_req_r <= 1'b0;
         ready_r <= 1'b0;
         fv_r <= 1'b0;
         fd_r <= '0;
         fb_r <= '0;
         mv_r <= 1'b0;
         md_r <= '0;
         mb_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         addr_r <= addr_nxt;
         way_r <= way_nxt;
         alloc_r <= alloc_nxt;
         inprio_r <= inprio_nxt;
         cnt_r <= cnt_nxt;
         ext_req_r <= ereq_nxt;
         ready_r <= ready_nxt;
         fv_r <= fv_nxt;
         fd_r <= fd_nxt;
         fb_r <= fb_nxt;
         mv_r <= mv_nxt;
         md_r <= md_nxt;
         mb_r <= mb_nxt;
      end
   end

   // Valid and age need reset; tags, priority and data do not
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         valid_r <= '0;
         for (int i = 0; i < icache_pkg::LINES; i++) begin
            age_r[i] <= 2'(i);
         end
      end else begin
         if (lru_en) begin
            for (int i = 0; i < icache_pkg::WAYS; i++) begin
               age_r[{lru_set, 2'(i)}] <= age4_nxt[i];
            end
         end
         if (fill_done) begin
            valid_r[{set_of(addr_r), way_r}] <= 1'b1;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (fill_done) begin
         tag_r[{set_of(addr_r), way_r}] <= tag_of(addr_r);
         prio_r[{set_of(addr_r), way_r}] <= inprio_r;
      end
      if (dwe) begin
         data_r[dwi] <= dwd;
      end
   end

   sync_fifo #(
      .WIDTH(icache_pkg::DATA_W),
      .DEPTH(icache_pkg::FIFO_DEPTH)
   ) u_fill_buf (
      .clock(clock),
      .arst_n(arst_n),
      .in_valid(ext_rvalid),
      .in_ready(ext_rready),
      .in_data(ext_rdata),
      .out_valid(q_valid),
      .out_ready(q_ready),
      .out_data(q_data)
   );

   assign fetch_ready = ready_r;
   assign fetch_valid = fv_r;
   assign fetch_data = fd_r;
   assign fetch_byte = fb_r;
   assign mem_valid = mv_r;
   assign mem_rdata = md_r;
   assign mem_blocked = mb_r;
   assign ext_req = ext_req_r;
   assign ext_addr = {addr_r[31:3], 3'h0};
   assign ext_burst = alloc_r;

   // ****************************************
   // Checks
   // ****************************************
   default clocking cb @(posedge clock); endclocking
   default disable iff (!arst_n);

   a_hit_answer: assert property (state_r == icache_pkg::S_IDLE &&
         fetch_req && ready_r && cache_enable && hit_any
         |=> fv_r && ready_r)
      else $error("hit not answered next cycle");
   a_block_cache: assert property (mem_req && in_region &&
         cache_enable |=> mb_r && !mv_r)
      else $error("direct access not refused in cache mode");
   a_req_hold: assert property (ext_req_r && !ext_gnt
         |=> ext_req_r && state_r == icache_pkg::S_REQ)
      else $error("bus request dropped before grant");
   a_fill_stays: assert property (state_r == icache_pkg::S_FILL &&
         !(take && last) |=> state_r == icache_pkg::S_FILL)
      else $error("fill left before its last word");
   a_lock_skip: assert property (state_r == icache_pkg::S_IDLE &&
         fetch_req && ready_r && !hit_any && alloc_nxt
         |-> !way_lock[vic[1:0]])
      else $error("locked way chosen as victim");
   a_first_word: assert property (take && cnt_r == 2'h0
         |=> fv_r && fd_r == $past(q_data))
      else $error("target word not delivered first");
   a_fill_valid: assert property (take && last && alloc_r
         |=> valid_r[{set_of(addr_r), way_r}] &&
         age_r[{set_of(addr_r), way_r}] == 2'h0)
      else $error("filled line not valid and most recent");
   a_no_alloc_burst: assert property (state_r == icache_pkg::S_IDLE &&
         fetch_req && ready_r && !cache_enable
         |=> ext_req_r && !ext_burst)
      else $error("uncached fetch asked for a burst");
   a_line_store: assert property (take && alloc_r
         |=> data_r[$past(dwi)] == $past(q_data))
      else $error("fill word not stored");
   a_invalid_first: assert property (state_r == icache_pkg::S_IDLE &&
         fetch_req && ready_r && cache_enable && !hit_any &&
         !vld4[0] && !way_lock[0] |-> vic == 3'h4)
      else $error("lowest invalid way not chosen");

   c_hit: cover property (fv_r && state_r == icache_pkg::S_IDLE);
   c_fill: cover property (take && last && alloc_r);
   c_blocked: cover property (mb_r);
   c_stall: cover property (!ext_rready && ext_rvalid);
endmodule

// *** tb/ext_mem_model.sv ***
// ****************************************
// External memory seen through the access bus
// ****************************************
module ext_mem_model (
   input wire logic clock,
   input wire logic arst_n,
   input wire logic slow,
   input wire logic ext_req,
   input wire logic [31:0] ext_addr,
   input wire logic ext_burst,
   input wire logic ext_rready,
   output logic ext_gnt,
   output logic ext_rvalid,
   output logic [63:0] ext_rdata
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [31:0] base;
   logic [1:0] wd;
   int n;
   function automatic logic [63:0] word(logic [31:0] a);
      return {a[31:3], 3'h0, ~a[31:3], 3'h0};
   endfunction
   initial begin
      ext_gnt = 1'b0;
      ext_rvalid = 1'b0;
      ext_rdata = 64'h0000_0000_0000_0000;
   end
   // Slow mode delays the grant and idles between words
   always begin
      @(posedge clock);
      if (arst_n && ext_req) begin
         if (slow) repeat (3) @(posedge clock);
         ext_gnt <= 1'b1;
         @(posedge clock);
         ext_gnt <= 1'b0;
         base = ext_addr;
         n = ext_burst ? 4 : 1;
         for (int k = 0; k < n; k++) begin
            wd = base[4:3] + 2'(k);
            ext_rvalid <= 1'b1;
            ext_rdata <= word({base[31:5], wd, 3'h0});
            do @(posedge clock); while (ext_rready !== 1'b1);
            if (slow) begin
               ext_rvalid <= 1'b0;
               ext_rdata <= ~ext_rdata;
               @(posedge clock);
            end
         end
         // Released data must not look like the last word
         ext_rvalid <= 1'b0;
         if (!slow) ext_rdata <= ~ext_rdata;
      end
   end
endmodule

// *** tb/instruction_cache_4way_test.sv ***
// ****************************************
// Fetch, fill and direct access bench
// ****************************************
module instruction_cache_4way_test;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct {
      logic [31:0] a;
      logic m, b;
      logic [3:0] lk;
      logic p, ml, ce;
   } row_t;
   logic clock = 1'b0;
   logic arst_n = 1'b0;
   logic cache_enable = 1'b1, modified_lru = 1'b0, line_prio = 1'b0;
   logic [3:0] way_lock = 4'h0;
   logic fetch_req = 1'b0, mem_req = 1'b0, mem_we = 1'b0, slow = 1'b0;
   logic [31:0] fetch_addr = 32'h0000_0000, mem_addr = 32'h0000_0000;
   logic [63:0] mem_wdata = 64'h0000_0000_0000_0000;
   logic fetch_ready, fetch_valid, mem_valid, mem_blocked;
   logic [63:0] fetch_data, mem_rdata, ext_rdata;
   logic [7:0] fetch_byte;
   logic ext_req, ext_burst, ext_gnt, ext_rvalid, ext_rready;
   logic [31:0] ext_addr, last_addr;
   logic last_burst;
   int n_mismatch = 0, samples_checked = 0, n_ext = 0;
   // Columns: address, miss, burst, lock, prio, modified, enable
   row_t rows [37] = '{
      '{32'h0000_4008,1,1,4'h0,0,0,1}, '{32'h0000_4018,0,0,4'h0,0,0,1},
      '{32'h0000_4003,0,0,4'h0,0,0,1}, '{32'h0000_8000,1,1,4'h0,0,0,1},
      '{32'h0000_C000,1,1,4'h0,0,0,1}, '{32'h0001_0000,1,1,4'h0,0,0,1},
      '{32'h0000_4010,0,0,4'h0,0,0,1}, '{32'h0000_8000,0,0,4'h0,0,0,1},
      '{32'h0000_C000,0,0,4'h0,0,0,1}, '{32'h0001_0000,0,0,4'h0,0,0,1},
      '{32'h0000_4000,0,0,4'h0,0,0,1}, '{32'h0001_4000,1,1,4'h0,0,0,1},
      '{32'h0000_8000,1,1,4'h0,0,0,1}, '{32'h0000_4000,0,0,4'h0,0,0,1},
      '{32'h0000_C000,1,1,4'h0,0,0,1}, '{32'h0000_5000,1,1,4'h0,0,0,1},
      '{32'h0000_4020,1,1,4'h0,0,0,1}, '{32'h0000_4400,1,1,4'h0,0,0,1},
      '{32'h0000_4000,0,0,4'h0,0,0,1}, '{32'h0000_4040,1,1,4'h0,1,1,1},
      '{32'h0000_8040,1,1,4'h0,1,1,1}, '{32'h0000_C040,1,1,4'h0,1,1,1},
      '{32'h0001_0040,1,1,4'h0,1,1,1}, '{32'h0001_4040,1,0,4'h0,0,1,1},
      '{32'h0001_4040,1,0,4'h0,0,1,1}, '{32'h0001_8040,1,1,4'h0,1,1,1},
      '{32'h0001_8040,0,0,4'h0,1,1,1}, '{32'h0000_4060,1,1,4'h0,0,0,1},
      '{32'h0000_8060,1,1,4'h1,0,0,1}, '{32'h0000_C060,1,1,4'h1,0,0,1},
      '{32'h0001_0060,1,1,4'h1,0,0,1}, '{32'h0001_4060,1,1,4'h1,0,0,1},
      '{32'h0000_4060,0,0,4'h1,0,0,1}, '{32'h0000_8060,1,1,4'h1,0,0,1},
      '{32'h0001_8060,1,0,4'hF,0,0,1}, '{32'h0001_8060,1,0,4'hF,0,0,1},
      '{32'h0000_4000,1,0,4'h0,0,0,0}};

   icache_ctrl icache_ctrl_i (.clock, .arst_n, .cache_enable, .modified_lru,
      .way_lock, .line_prio, .fetch_req, .fetch_addr, .fetch_ready,
      .fetch_valid, .fetch_data, .fetch_byte, .mem_req, .mem_we, .mem_addr,
      .mem_wdata, .mem_valid, .mem_rdata, .mem_blocked, .ext_req, .ext_addr,
      .ext_burst, .ext_gnt, .ext_rvalid, .ext_rready, .ext_rdata);
   ext_mem_model ext_mem_model_i (.clock, .arst_n, .slow, .ext_req,
      .ext_addr, .ext_burst, .ext_rready, .ext_gnt, .ext_rvalid, .ext_rdata);

   always #2 clock = ~clock;
   always @(posedge clock) begin
      if (ext_req && ext_gnt) begin
         n_ext <= n_ext + 1;
         last_addr <= ext_addr;
         last_burst <= ext_burst;
      end
   end

   function automatic logic [63:0] pat(logic [31:0] a);
      return {a[31:3], 3'h0, ~a[31:3], 3'h0};
   endfunction
   task automatic check(logic [63:0] seen, logic [63:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic tally_and_finish;
      $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   task automatic do_reset(int n);
      arst_n = 1'b0;
      repeat (n) @(negedge clock);
      check(ext_rready, 1'b1);
      check(fetch_ready, 1'b0);
      arst_n = 1'b1;
      repeat (2) @(negedge clock);
   endtask
   // Waits are bounded so a stuck handshake shows as a mismatch
   task automatic fetch(row_t r);
      int base, k;
      logic [63:0] w;
      cache_enable = r.ce;
      modified_lru = r.ml;
      way_lock = r.lk;
      line_prio = r.p;
      for (k = 0; k < 200 && fetch_ready !== 1'b1; k++) @(negedge clock);
      base = n_ext;
      fetch_req = 1'b1;
      fetch_addr = r.a;
      @(negedge clock);
      fetch_req = 1'b0;
      for (k = 0; k < 200 && fetch_valid !== 1'b1; k++) @(negedge clock);
      w = pat(r.a);
      check(fetch_valid, 1'b1);
      check(fetch_data, w);
      check(fetch_byte, w[r.a[2:0] * 8 +: 8]);
      check(64'(n_ext - base), r.m);
      if (r.m) begin
         check(last_addr, {r.a[31:3], 3'h0});
         check(last_burst, r.b);
      end
      @(negedge clock);
   endtask
   task automatic mem(logic we, logic [31:0] a, logic [63:0] d, logic v,
         logic bl);
      mem_req = 1'b1;
      mem_we = we;
      mem_addr = a;
      mem_wdata = d;
      @(negedge clock);
      mem_req = 1'b0;
      check(mem_valid, v);
      check(mem_blocked, bl);
      if (v) check(mem_rdata, d);
      @(negedge clock);
   endtask

   initial begin
      row_t r;
      do_reset(12);
      foreach (rows[i]) fetch(rows[i]);
      cache_enable = 1'b1;
      mem(1'b0, 32'hFFA1_0008, 64'h0000_0000_0000_0000, 1'b0, 1'b1);
      cache_enable = 1'b0;
      mem(1'b1, 32'hFFA1_0010, 64'h1234_5678_9ABC_DEF0, 1'b0, 1'b0);
      mem(1'b0, 32'hFFA1_0010, 64'h1234_5678_9ABC_DEF0, 1'b1, 1'b0);
      mem(1'b0, 32'h0000_0010, 64'h0000_0000_0000_0000, 1'b0, 1'b0);
      // Turning the cache off after the line request, before its grant, must not cut the fill short
      slow = 1'b1;
      r = '{32'h0002_0000, 1, 1, 4'h0, 0, 0, 1};
      fork
         fetch(r);
         begin
            repeat (4) @(negedge clock);
            cache_enable = 1'b0;
         end
      join
      slow = 1'b0;
      r.m = 1'b0;
      fetch(r);
      do_reset(2);
      r.a = 32'h0000_4000;
      r.m = 1'b1;
      fetch(r);
      // Direct reads stall the drain; the buffer must hold the whole burst
      r.a = 32'h0000_4020;
      fork
         fetch(r);
         begin
            wait (ext_req === 1'b1);
            @(negedge clock);
            cache_enable = 1'b0;
            mem_we = 1'b0;
            mem_addr = 32'hFFA1_0000;
            mem_req = 1'b1;
            repeat (8) @(negedge clock);
            check(ext_rready, 1'b1);
            check(fetch_valid, 1'b0);
            check(mem_valid, 1'b1);
            check(mem_rdata, pat(32'h0000_4000));
            mem_req = 1'b0;
         end
      join
      r.m = 1'b0;
      fetch(r);
      tally_and_finish;
   end
   initial begin
      #200us;
      n_mismatch++;
      tally_and_finish;
   end
endmodule
